// ==== src/lhb_pkg.sv ====
// Shared constants and types of the LCD host bus interface
package lhb_pkg;
   localparam int         BUS_W          = 8;
   // Port mode code is {port_class_strap, port_variant_strap}
   localparam logic [1:0] MODE_SPI4      = 2'h0;
   localparam logic [1:0] MODE_SPI3      = 2'h1;
   localparam logic [1:0] MODE_SEP       = 2'h2;
   localparam logic [1:0] MODE_ENA       = 2'h3;
   localparam logic [1:0] MODE_RST       = 2'h3;
   localparam int         MODE_CLASS_BIT = 1;
   // Bus lines that may carry select and command/data in serial mode
   localparam int         SER_CS_BIT     = 4;
   localparam int         SER_CD_BIT     = 5;
   // Last bit index of a serial frame
   localparam logic [3:0] SPI4_LAST      = 4'h7;
   localparam logic [3:0] SPI3_LAST      = 4'h8;
   localparam logic [3:0] CNT_RST        = 4'h0;
   localparam logic [7:0] BYTE_RST       = 8'h00;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ  = 3'b100
   } lhb_state_e;
endpackage : lhb_pkg

// ==== src/lhb_byte_if.sv ====
// Byte stream with command/data qualifier between internal stages
`timescale 1ns/100ps
interface lhb_byte_if #(
   parameter int W = 8
);
   logic         valid;
   logic         ready;
   logic [W-1:0] data;
   logic         is_data;
   modport src (output valid, output data, output is_data, input ready);
   modport snk (input valid, input data, input is_data, output ready);
endinterface : lhb_byte_if

// ==== src/lhb_serial_rx.sv ====
// Serial receiver for the three- and four-wire host modes
`timescale 1ns/100ps
module lhb_serial_rx (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic clear,
   input  wire logic enable,
   input  wire logic three_wire,
   input  wire logic sck,
   input  wire logic sda,
   input  wire logic cs_active,
   input  wire logic cd_pin,
   lhb_byte_if.src   byte_o
);
   localparam int W = lhb_pkg::BUS_W;
   logic         sck_prev_reg, sck_prev_next;
   logic [3:0]   cnt_reg, cnt_next;
   logic [W-1:0] shift_reg, shift_next;
   logic         cd_reg, cd_next;
   logic         valid_reg, valid_next;
   logic [W-1:0] byte_reg, byte_next;
   logic         isd_reg, isd_next;
   logic         rise;
   logic [3:0]   last;

   always_comb begin
      rise = sck & ~sck_prev_reg;
      last = three_wire ? lhb_pkg::SPI3_LAST : lhb_pkg::SPI4_LAST;
      sck_prev_next = sck;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      cd_next = cd_reg;
      valid_next = valid_reg & ~byte_o.ready;
      byte_next = byte_reg;
      isd_next = isd_reg;
      // A deselect aborts a partial frame
      if (!enable || !cs_active) begin
         cnt_next = lhb_pkg::CNT_RST;
      end else if (rise) begin // see [RULE9]
         if (three_wire && cnt_reg == lhb_pkg::CNT_RST) begin
            cd_next = sda;
         end else begin
            shift_next = {shift_reg[W-2:0], sda};
         end
         if (cnt_reg == last) begin
            cnt_next = lhb_pkg::CNT_RST;
            valid_next = 1'b1;
            byte_next = {shift_reg[W-2:0], sda};
            isd_next = three_wire ? cd_reg : cd_pin; // see [RULE1]
         end else begin
            cnt_next = cnt_reg + 4'h1;
         end
      end
      if (clear) begin
         cnt_next = lhb_pkg::CNT_RST;
         valid_next = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sck_prev_reg <= 1'b0;
         cnt_reg <= lhb_pkg::CNT_RST;
         shift_reg <= lhb_pkg::BYTE_RST;
         cd_reg <= 1'b0;
         valid_reg <= 1'b0;
         byte_reg <= lhb_pkg::BYTE_RST;
         isd_reg <= 1'b0;
      end else begin
         sck_prev_reg <= sck_prev_next;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         cd_reg <= cd_next;
         valid_reg <= valid_next;
         byte_reg <= byte_next;
         isd_reg <= isd_next;
      end
   end

   assign byte_o.valid = valid_reg;
   assign byte_o.data = byte_reg;
   assign byte_o.is_data = isd_reg;

   byte_done_a: assert property (@(posedge clk) disable iff (rst) // see [RULE9]
      $rose(valid_reg) |-> $past(rise) && ($past(cnt_reg) == $past(last)))
      else $error("serial byte completed without its last clock edge");
endmodule : lhb_serial_rx

// ==== src/lhb_skid_buf.sv ====
// Two-entry buffer between the capture logic and the user side
`timescale 1ns/100ps
module lhb_skid_buf #(
   parameter int W = 8
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic flush,
   lhb_byte_if.snk   in_if,
   lhb_byte_if.src   out_if
);
   if (W < 1) begin : g_bad_w
      $error("lhb_skid_buf: W must be at least 1");
   end
   logic         ov_reg, ov_next;
   logic [W:0]   ow_reg, ow_next;
   logic         sv_reg, sv_next;
   logic [W:0]   sw_reg, sw_next;
   logic         take, pop;

   always_comb begin
      take = in_if.valid & ~sv_reg;
      pop = ov_reg & out_if.ready;
      ov_next = ov_reg;
      ow_next = ow_reg;
      sv_next = sv_reg;
      sw_next = sw_reg;
      if (pop) begin
         ov_next = sv_reg;
         ow_next = sw_reg;
         sv_next = 1'b0;
      end
      if (take) begin
         if (ov_next) begin
            sv_next = 1'b1;
            sw_next = {in_if.is_data, in_if.data};
         end else begin
            ov_next = 1'b1;
            ow_next = {in_if.is_data, in_if.data};
         end
      end
      if (flush) begin
         ov_next = 1'b0;
         sv_next = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ov_reg <= 1'b0;
         ow_reg <= '0;
         sv_reg <= 1'b0;
         sw_reg <= '0;
      end else begin
         ov_reg <= ov_next;
         ow_reg <= ow_next;
         sv_reg <= sv_next;
         sw_reg <= sw_next;
      end
   end

   // Ready comes from a flop so the source never sees a combinational path
   assign in_if.ready = ~sv_reg;
   assign out_if.valid = ov_reg;
   assign out_if.data = ow_reg[W-1:0];
   assign out_if.is_data = ow_reg[W];

   stall_hold_a: assert property (@(posedge clk) disable iff (rst)
      ov_reg && !out_if.ready && !flush |=> ov_reg && $stable(ow_reg))
      else $error("buffered word changed while the receiver stalled");
endmodule : lhb_skid_buf

// ==== src/lhb_host_port.sv ====
// Host bus interface of the LCD controller: parallel and serial byte transport
//
// Overview of operation
// [RULE1] The command/data select marks each byte as display data when high and as a command when low.
// [RULE2] While hw_init_low is low every piece of control state returns to its default; the code keeps rd_is_data and loads the mode from the straps.
// [RULE3] In enable-strobe mode a high strobe marks an active transfer, read or write.
// [RULE4] In enable-strobe mode a high direction makes a read with the bus driven, low makes a write.
// [RULE5] In separate-strobe mode a low strobe pin is a read and the bus is driven while it lasts.
// [RULE6] In separate-strobe mode a low direction pin is a write and the bus byte is taken in.
// [RULE7] In serial mode the host holds the strobe and direction pins high and never toggles them.
// [RULE8] In either parallel mode the eight bus lines form a two-way byte bus.
// [RULE9] In serial mode clock, data, select and command/data are taken from chosen bus lines or pins.
// [RULE10] The two straps pick four-wire serial, three-wire serial, separate-strobe or enable-strobe.
// [RULE11] A written byte and its qualifier are captured at the trailing edge of the write strobe.
`timescale 1ns/100ps
module lhb_host_port #(
   parameter int SCK_BIT   = 7,
   parameter int SDA_BIT   = 6,
   parameter int CS_ON_BUS = 0,
   parameter int CD_ON_BUS = 0
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       hw_init_low,
   input  wire logic       port_class_strap,
   input  wire logic       port_variant_strap,
   input  wire logic       chip_select_n,
   input  wire logic       cmd_data_select,
   input  wire logic       strobe_pin,
   input  wire logic       dir_pin,
   input  wire logic [7:0] host_bus_lines_i,
   output logic      [7:0] host_bus_lines_o,
   output logic            host_bus_lines_oe,
   output logic            rx_valid,
   input  wire logic       rx_ready,
   output logic      [7:0] rx_byte,
   output logic            rx_is_data,
   input  wire logic [7:0] rd_byte,
   output logic            rd_is_data,
   output logic            rd_done,
   output logic            overrun,
   output logic      [1:0] port_mode
);
   if (SCK_BIT != 7 && SCK_BIT != 0) begin : g_bad_sck
      $error("lhb_host_port: SCK_BIT must be 7 or 0");
   end
   if (SDA_BIT != 6 && SDA_BIT != 1 && SDA_BIT != 2 && SDA_BIT != 3) begin : g_bad_sda
      $error("lhb_host_port: SDA_BIT must be 6, 1, 2 or 3");
   end
   if (CS_ON_BUS < 0 || CS_ON_BUS > 1 || CD_ON_BUS < 0 || CD_ON_BUS > 1) begin : g_bad_map
      $error("lhb_host_port: CS_ON_BUS and CD_ON_BUS must be 0 or 1");
   end

   localparam int W = lhb_pkg::BUS_W;

   // Mode group
   logic [1:0]          mode_reg, mode_next;
   logic                loaded_reg, loaded_next;
   // Parallel group
   lhb_pkg::lhb_state_e state_reg, state_next;
   logic [W-1:0]        wr_byte_reg, wr_byte_next;
   logic                wr_cd_reg, wr_cd_next;
   logic                rd_sel_reg, rd_sel_next;
   logic [W-1:0]        bus_o_reg, bus_o_next;
   logic                oe_reg, oe_next;
   logic                rd_done_reg, rd_done_next;
   logic                overrun_reg, overrun_next;
   // Decoded pin roles
   logic                par_mode, ena_mode, cs_act;
   logic                wr_act, rd_act, par_push;
   logic                ser_sck, ser_sda, ser_cs, ser_cd;

   lhb_byte_if #(.W(W)) ser_if ();
   lhb_byte_if #(.W(W)) buf_in ();
   lhb_byte_if #(.W(W)) buf_out ();

   // Straps are re-read while initialisation is held and once after reset
   always_comb begin
      loaded_next = 1'b1;
      if (!hw_init_low || !loaded_reg) begin
         mode_next = {port_class_strap, port_variant_strap}; // see [RULE10]
      end else begin
         mode_next = mode_reg;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         mode_reg <= lhb_pkg::MODE_RST;
         loaded_reg <= 1'b0;
      end else begin
         mode_reg <= mode_next;
         loaded_reg <= loaded_next;
      end
   end

   // Strobe decode: write wins when both strobes are low in separate mode
   always_comb begin
      par_mode = mode_reg[lhb_pkg::MODE_CLASS_BIT];
      ena_mode = (mode_reg == lhb_pkg::MODE_ENA);
      cs_act = ~chip_select_n;
      if (ena_mode) begin
         wr_act = cs_act & strobe_pin & ~dir_pin; // see [RULE3] see [RULE4]
         rd_act = cs_act & strobe_pin & dir_pin; // see [RULE3] see [RULE4]
      end else begin
         wr_act = cs_act & par_mode & ~dir_pin; // see [RULE6]
         rd_act = cs_act & par_mode & ~strobe_pin & dir_pin; // see [RULE5]
      end
   end

   always_comb begin
      state_next = state_reg;
      wr_byte_next = wr_byte_reg;
      wr_cd_next = wr_cd_reg;
      rd_sel_next = rd_sel_reg;
      bus_o_next = bus_o_reg;
      oe_next = 1'b0;
      rd_done_next = 1'b0;
      overrun_next = overrun_reg;
      par_push = 1'b0;
      case (state_reg)
         lhb_pkg::ST_IDLE: begin
            if (wr_act) begin
               state_next = lhb_pkg::ST_WRITE;
               wr_byte_next = host_bus_lines_i;
               wr_cd_next = cmd_data_select; // see [RULE1]
            end else if (rd_act) begin
               state_next = lhb_pkg::ST_READ;
               rd_sel_next = cmd_data_select; // see [RULE1]
               bus_o_next = rd_byte;
               oe_next = 1'b1; // see [RULE8]
            end
         end
         lhb_pkg::ST_WRITE: begin
            // Track the bus until the strobe ends so late settling data is kept
            if (wr_act) begin
               wr_byte_next = host_bus_lines_i;
               wr_cd_next = cmd_data_select;
            end else begin
               state_next = lhb_pkg::ST_IDLE;
               par_push = 1'b1; // see [RULE11]
               if (!buf_in.ready) begin
                  overrun_next = 1'b1;
               end
            end
         end
         lhb_pkg::ST_READ: begin
            if (rd_act) begin
               bus_o_next = rd_byte;
               oe_next = 1'b1; // see [RULE8]
            end else begin
               state_next = lhb_pkg::ST_IDLE;
               rd_done_next = 1'b1;
            end
         end
         default: begin
            state_next = lhb_pkg::ST_IDLE;
         end
      endcase
      // Initialisation wins over a byte that ends in the same cycle
      if (!hw_init_low) begin // see [RULE2]
         state_next = lhb_pkg::ST_IDLE;
         oe_next = 1'b0;
         rd_done_next = 1'b0;
         overrun_next = 1'b0;
         par_push = 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= lhb_pkg::ST_IDLE;
         wr_byte_reg <= lhb_pkg::BYTE_RST;
         wr_cd_reg <= 1'b0;
         rd_sel_reg <= 1'b0;
         bus_o_reg <= lhb_pkg::BYTE_RST;
         oe_reg <= 1'b0;
         rd_done_reg <= 1'b0;
         overrun_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         wr_byte_reg <= wr_byte_next;
         wr_cd_reg <= wr_cd_next;
         rd_sel_reg <= rd_sel_next;
         bus_o_reg <= bus_o_next;
         oe_reg <= oe_next;
         rd_done_reg <= rd_done_next;
         overrun_reg <= overrun_next;
      end
   end

   // Serial pin roles; the strobe pins are idle by host convention here
   always_comb begin
      ser_sck = host_bus_lines_i[SCK_BIT]; // see [RULE9]
      ser_sda = host_bus_lines_i[SDA_BIT]; // see [RULE9]
      ser_cs = (CS_ON_BUS != 0) ? ~host_bus_lines_i[lhb_pkg::SER_CS_BIT] : cs_act; // see [RULE9]
      ser_cd = (CD_ON_BUS != 0) ? host_bus_lines_i[lhb_pkg::SER_CD_BIT] : cmd_data_select;
   end

   lhb_serial_rx u_serial (
      .clk        (clk),
      .rst        (rst),
      .clear      (~hw_init_low),
      .enable     (~par_mode),
      .three_wire (mode_reg == lhb_pkg::MODE_SPI3),
      .sck        (ser_sck),
      .sda        (ser_sda),
      .cs_active  (ser_cs),
      .cd_pin     (ser_cd),
      .byte_o     (ser_if.src)
   );

   // Modes are exclusive, so the two sources never compete for the buffer
   assign buf_in.valid = par_push | (ser_if.valid & ~par_mode);
   assign buf_in.data = par_mode ? wr_byte_reg : ser_if.data;
   assign buf_in.is_data = par_mode ? wr_cd_reg : ser_if.is_data;
   assign ser_if.ready = buf_in.ready & ~par_mode;

   lhb_skid_buf #(.W(W)) u_buf (
      .clk    (clk),
      .rst    (rst),
      .flush  (~hw_init_low),
      .in_if  (buf_in.snk),
      .out_if (buf_out.src)
   );

   assign buf_out.ready = rx_ready;
   assign rx_valid = buf_out.valid;
   assign rx_byte = buf_out.data;
   assign rx_is_data = buf_out.is_data;
   assign host_bus_lines_o = bus_o_reg;
   assign host_bus_lines_oe = oe_reg;
   assign rd_is_data = rd_sel_reg;
   assign rd_done = rd_done_reg;
   assign overrun = overrun_reg;
   assign port_mode = mode_reg;

   cd_track_a: assert property (@(posedge clk) disable iff (rst) // see [RULE1]
      hw_init_low && wr_act |=> wr_cd_reg == $past(cmd_data_select))
      else $error("write qualifier not taken from command/data select");

   init_clear_a: assert property (@(posedge clk) disable iff (rst) // see [RULE2]
      !hw_init_low |=> state_reg == lhb_pkg::ST_IDLE && !host_bus_lines_oe
                       && !rx_valid && !overrun)
      else $error("initialisation did not restore defaults");

   ena_strobe_a: assert property (@(posedge clk) disable iff (rst) // see [RULE3]
      hw_init_low && ena_mode && !strobe_pin && state_reg == lhb_pkg::ST_IDLE
      |=> state_reg == lhb_pkg::ST_IDLE)
      else $error("transfer started without the enable strobe");

   ena_read_a: assert property (@(posedge clk) disable iff (rst) // see [RULE4]
      hw_init_low && ena_mode && cs_act && strobe_pin && dir_pin
      && state_reg == lhb_pkg::ST_IDLE |=> state_reg == lhb_pkg::ST_READ && host_bus_lines_oe)
      else $error("enable-mode read did not drive the bus");

   sep_read_a: assert property (@(posedge clk) disable iff (rst) // see [RULE5]
      hw_init_low && mode_reg == lhb_pkg::MODE_SEP && cs_act && !strobe_pin && dir_pin
      && state_reg != lhb_pkg::ST_WRITE |=> host_bus_lines_oe)
      else $error("read strobe low without bus drive");

   sep_write_a: assert property (@(posedge clk) disable iff (rst) // see [RULE6]
      hw_init_low && mode_reg == lhb_pkg::MODE_SEP && cs_act && !dir_pin
      && state_reg == lhb_pkg::ST_IDLE |=> state_reg == lhb_pkg::ST_WRITE)
      else $error("write strobe low did not start a write");

   bus_drive_a: assert property (@(posedge clk) disable iff (rst) // see [RULE8]
      host_bus_lines_oe |-> par_mode && host_bus_lines_o == $past(rd_byte))
      else $error("bus driven outside a parallel read or with stale data");

   strap_mode_a: assert property (@(posedge clk) disable iff (rst) // see [RULE10]
      !hw_init_low |=> port_mode == {$past(port_class_strap), $past(port_variant_strap)})
      else $error("port mode does not follow the straps");

   trail_push_a: assert property (@(posedge clk) disable iff (rst) // see [RULE11]
      hw_init_low && state_reg == lhb_pkg::ST_WRITE && !wr_act && buf_in.ready
      |=> rx_valid ##0 !$past(host_bus_lines_oe))
      else $error("byte not delivered after the write strobe ended");
endmodule : lhb_host_port

// ==== verification/lhb_host_model.sv ====
// Behavioural host processor driving the parallel and serial pins
`timescale 1ns/100ps
module lhb_host_model (
   input  wire logic       clk,
   output logic            chip_select_n,
   output logic            cmd_data_select,
   output logic            strobe_pin,
   output logic            dir_pin,
   output logic      [7:0] bus_drv
);
   logic ena_mode;

   initial begin
      chip_select_n = 1'b1;
      cmd_data_select = 1'b0;
      strobe_pin = 1'b0;
      dir_pin = 1'b1;
      bus_drv = 8'h00;
      ena_mode = 1'b1;
   end

   // Serial modes park both strobes high and never touch them
   task automatic set_mode(input logic ena);
      ena_mode = ena;
      strobe_pin <= !ena;
      dir_pin <= 1'b1;
   endtask : set_mode

   task automatic wr(input logic cd, input logic [7:0] b);
      @(posedge clk);
      chip_select_n <= 1'b0;
      cmd_data_select <= cd;
      bus_drv <= b;
      dir_pin <= 1'b0;
      // Enable high, or the read strobe parked high so both strobes never overlap
      strobe_pin <= 1'b1;
      repeat (2) @(posedge clk);
      dir_pin <= 1'b1;
      strobe_pin <= !ena_mode;
      bus_drv <= ~b;
      @(posedge clk);
      chip_select_n <= 1'b1;
      @(posedge clk);
   endtask : wr

   task automatic rd_start(input logic cd);
      @(posedge clk);
      chip_select_n <= 1'b0;
      cmd_data_select <= cd;
      bus_drv <= ~bus_drv;
      dir_pin <= 1'b1;
      strobe_pin <= ena_mode;
   endtask : rd_start

   task automatic rd_stop;
      @(posedge clk);
      strobe_pin <= !ena_mode;
      @(posedge clk);
      chip_select_n <= 1'b1;
   endtask : rd_stop

   // Serial clock stands low outside frames
   task automatic ser(input logic three, input logic cd, input logic [7:0] b);
      logic [8:0] bits;
      int         n;
      bits = three ? {cd, b} : {b, 1'b0};
      n = three ? 9 : 8;
      @(posedge clk);
      chip_select_n <= 1'b0;
      cmd_data_select <= cd;
      for (int i = 0; i < n; i++) begin
         bus_drv[6] <= bits[8-i];
         bus_drv[7] <= 1'b0;
         repeat (2) @(posedge clk);
         bus_drv[7] <= 1'b1;
         repeat (2) @(posedge clk);
      end
      bus_drv[7] <= 1'b0;
      @(posedge clk);
      chip_select_n <= 1'b1;
      bus_drv[6] <= ~bus_drv[6];
      @(posedge clk);
   endtask : ser
endmodule : lhb_host_model

// ==== verification/lcd_host_bus_interface_tb_top.sv ====
// Self-checking bench of the host port against a queue model
`timescale 1ns/100ps
module lcd_host_bus_interface_tb_top;
   logic       clk;
   logic       rst;
   logic       hw_init_low;
   logic       cls;
   logic       var_s;
   logic       rx_ready;
   logic       stall;
   logic [7:0] rd_byte;
   logic       cs_n;
   logic       cd;
   logic       strobe;
   logic       dir;
   logic [7:0] bus_drv;
   logic [7:0] bus_i;
   logic [7:0] bus_o;
   logic       bus_oe;
   logic       rx_valid;
   logic [7:0] rx_byte;
   logic       rx_is_data;
   logic       rd_is_data;
   logic       rd_done;
   logic       overrun;
   logic [1:0] port_mode;
   int         err_count;
   int         comparisons;
   int         seed;
   logic [8:0] q[$];

   assign bus_i = bus_oe ? bus_o : bus_drv;

   lhb_host_model u_lhb_host_model (.clk(clk), .chip_select_n(cs_n), .cmd_data_select(cd),
      .strobe_pin(strobe), .dir_pin(dir), .bus_drv(bus_drv));

   lhb_host_port u_lhb_host_port (.clk(clk), .rst(rst), .hw_init_low(hw_init_low),
      .port_class_strap(cls), .port_variant_strap(var_s), .chip_select_n(cs_n),
      .cmd_data_select(cd), .strobe_pin(strobe), .dir_pin(dir), .host_bus_lines_i(bus_i),
      .host_bus_lines_o(bus_o), .host_bus_lines_oe(bus_oe), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_byte(rx_byte), .rx_is_data(rx_is_data), .rd_byte(rd_byte),
      .rd_is_data(rd_is_data), .rd_done(rd_done), .overrun(overrun), .port_mode(port_mode));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input logic [8:0] exp, input logic [8:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : chk

   task automatic end_sim;
      $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim

   // Receiver stalls on random cycles, one in four on average with no bound on a run, and on every cycle while stall is set
   always @(posedge clk) begin
      rx_ready <= !stall && (2'($random(seed)) != 2'h0);
      if (!rst && rx_valid === 1'b1 && rx_ready === 1'b1) begin
         if (q.size() == 0) chk(9'h1FF, {rx_is_data, rx_byte});
         else chk(q.pop_front(), {rx_is_data, rx_byte});
      end
   end

   task automatic init_mode(input logic [1:0] m);
      @(posedge clk);
      cls <= m[1];
      var_s <= m[0];
      hw_init_low <= 1'b0;
      u_lhb_host_model.set_mode(m == lhb_pkg::MODE_ENA);
      repeat (2) @(posedge clk);
      hw_init_low <= 1'b1;
      q.delete();
      #1;
      chk({7'h00, m}, {7'h00, port_mode});
      chk(9'h000, {7'h00, overrun, rx_valid});
   endtask : init_mode

   task automatic drain;
      for (int k = 0; k < 400 && q.size() != 0; k++) @(posedge clk);
      chk(9'h000, 9'(q.size()));
      if (q.size() != 0) begin
         end_sim();
      end
   endtask : drain

   task automatic par_test;
      logic       c;
      logic [7:0] b;
      for (int i = 0; i < 6; i++) begin
         b = 8'($random(seed));
         c = (i < 2) ? i[0] : 1'($random(seed));
         q.push_back({c, b});
         u_lhb_host_model.wr(c, b);
      end
      drain();
      for (int i = 0; i < 3; i++) begin
         c = i[0];
         @(posedge clk);
         rd_byte <= 8'($random(seed));
         u_lhb_host_model.rd_start(c);
         repeat (3) @(posedge clk);
         #1;
         chk({1'b1, rd_byte}, {bus_oe, bus_i});
         chk({8'h00, c}, {8'h00, rd_is_data});
         u_lhb_host_model.rd_stop();
         // The done pulse lasts one cycle, so look just after each edge
         #1;
         for (int k = 0; k < 20 && rd_done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
         end
         chk(9'h100, {rd_done, 7'h00, bus_oe});
         if (rd_done !== 1'b1) begin
            end_sim();
         end
      end
      $display("parallel test done, mode %0d", port_mode);
   endtask : par_test

   task automatic ser_test(input logic three);
      logic       c;
      logic [7:0] b;
      for (int i = 0; i < 4; i++) begin
         b = 8'($random(seed));
         c = i[0];
         q.push_back({c, b});
         u_lhb_host_model.ser(three, c, b);
      end
      drain();
      $display("serial test done, three wire %0d", three);
   endtask : ser_test

   initial begin
      seed = 32'hd8bf;
      rst = 1'b1;
      hw_init_low = 1'b1;
      cls = 1'b1;
      var_s = 1'b1;
      stall = 1'b0;
      rd_byte = 8'h00;
      err_count = 0;
      comparisons = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({7'h00, lhb_pkg::MODE_ENA}, {7'h00, port_mode});
      par_test();
      stall <= 1'b1;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 3; i++) begin
         u_lhb_host_model.wr(1'b1, 8'(8'hA0 + i));
      end
      #1;
      chk({8'h00, 1'b1}, {8'h00, overrun});
      $display("fill test done");
      init_mode(lhb_pkg::MODE_SEP);
      stall <= 1'b0;
      par_test();
      init_mode(lhb_pkg::MODE_SPI4);
      ser_test(1'b0);
      init_mode(lhb_pkg::MODE_SPI3);
      ser_test(1'b1);
      end_sim();
   end

   initial begin
      #200000;
      err_count++;
      end_sim();
   end
endmodule : lcd_host_bus_interface_tb_top
